/* common/supervisor_defines.svh */
// constants for the supply supervisor and watchdog: timing counts and the ms-to-ticks conversion
// assumes a 100 MHz system clock and a prescaled internal tick
// Notes on behaviour
// - reset low while supply below threshold
// - reset held a further pulse after recovery
// - active-high reset is complement of reset
// - power-fail warning low when sense below reference
// - chip-select passes through when supply good
// - chip-select forced high when supply low
// - supply-low output follows threshold, no stretch
// - missing toggle for timeout gives reset pulse
// - reset pulses repeat each timeout without toggle
// - watchdog expiry drives timeout output low
// - timeout output low until next toggle
// - floating toggle input disables watchdog entirely
// - main-active output low while main above cell
// - backup mode when main below cell
// - source switching uses hysteresis comparator pair
// - timeout output forced high on low supply
// - watchdog restarts at end of every reset
// - below cell, warning forced low
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH
`define CLK_PERIOD_NS     10
`define TICK_PERIOD_NS    100000
`define TICK_DIV          (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define WDOG_TIMEOUT_MS   1600
`define RST_PULSE_MS      50
`define RST_PULSE_LONG_MS 200
`define MS_TO_TICKS(ms)   ((ms) * 1000000 / `TICK_PERIOD_NS)
`endif

/* common/supervisor_pkg.sv */
// types for the supply supervisor and watchdog
// assumes the defines header is compiled alongside
package supervisor_pkg;
  // digitised comparator results
  typedef struct packed {
    logic supply_ok;     // main supply above reset threshold
    logic pf_above;      // sense input above reference
    logic main_above_hi; // main above cell by the rising margin
    logic main_above_lo; // main above cell by the falling margin
  } sense_t;
  // reset sequencer states
  typedef enum logic [1:0] {ST_LOW, ST_PULSE, ST_RUN} rst_state_t;
endpackage

/* hdl/tick_counter.sv */
// loadable down counter that fires when it reaches zero on a tick
// assumes tick is a single-cycle pulse on the same clock
`timescale 1ns/1ps
module tick_counter #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,     // reload to start value
  input  wire logic [W-1:0] start,    // value loaded
  input  wire logic         tick,     // count enable pulse
  output logic              done      // count reached zero
);
  logic [W-1:0] cnt_q;                // remaining ticks
  logic [W-1:0] cnt_d;

  // next count: load wins, else decrement on tick
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = start;
    end else if (tick && cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  // count register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0);
endmodule

/* hdl/supply_supervisor_watchdog.sv */
// supply supervisor: reset generator, watchdog, chip-select gate, switchover
// assumes comparator results arrive as asynchronous digital levels
`timescale 1ns/1ps
`include "supervisor_defines.svh"
module supply_supervisor_watchdog #(
  parameter bit LONG_PULSE   = 1'b0,                            // 200 ms variant
  parameter int TICK_DIV     = `TICK_DIV,                       // clocks per tick
  parameter int WDOG_TICKS   = `MS_TO_TICKS(`WDOG_TIMEOUT_MS),  // timeout in ticks
  parameter int PULSE_TICKS  = LONG_PULSE ? `MS_TO_TICKS(`RST_PULSE_LONG_MS)
                                          : `MS_TO_TICKS(`RST_PULSE_MS)
) (
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  input  wire logic SUPPLY_OK,           // threshold comparator, high = good
  input  wire logic PF_ABOVE,            // power-fail comparator, high = above
  input  wire logic MAIN_ABOVE_HI,       // main exceeds cell by rising margin
  input  wire logic MAIN_ABOVE_LO,       // main exceeds cell by falling margin
  input  wire logic WATCHDOG_TOGGLE_IN,  // processor toggle line
  input  wire logic WDI_FLOATING,        // floating detector on toggle line
  input  wire logic CHIP_SELECT_IN_N,    // chip-select from decode
  output logic      RESET_N,             // active-low processor reset
  output logic      RESET,               // active-high reset
  output logic      POWER_FAIL_WARN_N,   // warning to processor nmi
  output logic      CHIP_SELECT_OUT_N,   // gated chip-select
  output logic      SUPPLY_LOW_N,        // low-supply indicator
  output logic      WATCHDOG_TIMEOUT_OUT_N, // watchdog expiry flag
  output logic      MAIN_SUPPLY_ACTIVE_N,   // pass transistor drive
  output logic      BACKUP_SELECT       // backed supply taken from cell
);
  import supervisor_pkg::*;

  localparam int CW = 24;                // counter width

  // elaboration check: counts must fit the prescaler and the counters
  if (TICK_DIV < 1 || TICK_DIV > 65536 || WDOG_TICKS < 2 || PULSE_TICKS < 1 ||
      WDOG_TICKS >= (1 << CW) || PULSE_TICKS >= (1 << CW)) begin : g_bad_timing
    $error("supervisor timing parameters out of range");
  end

  // two-flop synchronisers for every outside level
  logic [6:0] s1_q, s2_q;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s1_q <= 7'h00;
      s2_q <= 7'h00;
    end else begin
      s1_q <= {SUPPLY_OK, PF_ABOVE, MAIN_ABOVE_HI, MAIN_ABOVE_LO,
               WATCHDOG_TOGGLE_IN, WDI_FLOATING, CHIP_SELECT_IN_N};
      s2_q <= s1_q;
    end
  end

  sense_t sense;                         // synchronised comparator set
  logic   wdi_s, wdi_float_s, cs_in_s;   // synchronised logic inputs
  assign sense       = sense_t'(s2_q[6:3]);
  assign wdi_s       = s2_q[2];
  assign wdi_float_s = s2_q[1];
  assign cs_in_s     = s2_q[0];

  // prescaler producing the internal oscillator tick
  logic [15:0] pre_q, pre_d;
  logic        tick;
  always_comb begin
    tick  = (pre_q == 16'(TICK_DIV - 1));
    pre_d = tick ? 16'h0000 : pre_q + 16'h0001;
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_d;
    end
  end

  // toggle edge detect on the synchronised level
  logic wdi_prev_q, wdi_edge;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wdi_prev_q <= 1'b0;
    end else begin
      wdi_prev_q <= wdi_s;
    end
  end
  assign wdi_edge = wdi_s ^ wdi_prev_q;

  // separate counters on the shared tick: reset pulse width and watchdog timeout
  logic st_load_p, pulse_done;
  logic wd_load, wd_done;
  tick_counter #(.W(CW)) u_pulse (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .load  (st_load_p),
    .start (CW'(PULSE_TICKS)),
    .tick  (tick),
    .done  (pulse_done)
  );
  tick_counter #(.W(CW)) u_wdog (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .load  (wd_load),
    .start (CW'(WDOG_TICKS)),
    .tick  (tick),
    .done  (wd_done)
  );

  // reset sequencer state and watchdog flag
  rst_state_t st_q, st_d;
  logic       wdo_n_q, wdo_n_d;
  logic       wd_expire;
  always_comb begin
    st_d      = st_q;
    wdo_n_d   = wdo_n_q;
    st_load_p = 1'b0;
    wd_expire = (st_q == ST_RUN) && wd_done && !wdi_float_s;
    // restart timer at end of pulse, on every toggle, or while idle
    wd_load   = (st_q != ST_RUN) || wdi_edge || wd_expire;
    case (st_q)
      ST_LOW: begin
        if (sense.supply_ok) begin     // supply back: start hold pulse
          st_d      = ST_PULSE;
          st_load_p = 1'b1;
        end
      end
      ST_PULSE: begin
        if (!sense.supply_ok) begin
          st_d = ST_LOW;
        end else if (pulse_done) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!sense.supply_ok) begin
          st_d = ST_LOW;
        end else if (wd_expire) begin
          st_d      = ST_PULSE;
          st_load_p = 1'b1;
        end
      end
      default: st_d = ST_LOW;
    endcase
    // timeout flag: low on expiry, high on toggle or low supply
    if (!sense.supply_ok) begin
      wdo_n_d = 1'b1;
    end else if (wd_expire) begin
      wdo_n_d = 1'b0;
    end else if (wdi_edge) begin
      wdo_n_d = 1'b1;
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_q    <= ST_LOW;
      wdo_n_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      wdo_n_q <= wdo_n_d;
    end
  end

  // switchover hysteresis: rise at high margin, fall at low margin
  logic on_main_q, on_main_d;
  always_comb begin
    on_main_d = on_main_q;
    if (sense.main_above_hi) begin
      on_main_d = 1'b1;
    end else if (!sense.main_above_lo) begin
      on_main_d = 1'b0;
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      on_main_q <= 1'b0;
    end else begin
      on_main_q <= on_main_d;
    end
  end

  // registered pin outputs
  logic rst_n_d, pfw_n_d, cs_out_d;
  always_comb begin
    rst_n_d  = (st_d == ST_RUN);
    pfw_n_d  = on_main_d && sense.pf_above;
    cs_out_d = sense.supply_ok ? cs_in_s : 1'b1;
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RESET_N                <= 1'b0;
      RESET                  <= 1'b1;
      POWER_FAIL_WARN_N      <= 1'b0;
      CHIP_SELECT_OUT_N      <= 1'b1;
      SUPPLY_LOW_N           <= 1'b0;
      WATCHDOG_TIMEOUT_OUT_N <= 1'b1;
      MAIN_SUPPLY_ACTIVE_N   <= 1'b1;
      BACKUP_SELECT          <= 1'b1;
    end else begin
      RESET_N                <= rst_n_d;
      RESET                  <= !rst_n_d;
      POWER_FAIL_WARN_N      <= pfw_n_d;
      CHIP_SELECT_OUT_N      <= cs_out_d;
      SUPPLY_LOW_N           <= sense.supply_ok;
      WATCHDOG_TIMEOUT_OUT_N <= wdo_n_d;
      MAIN_SUPPLY_ACTIVE_N   <= !on_main_d;
      BACKUP_SELECT          <= !on_main_d;
    end
  end
endmodule

/* tb/supervisor_chk.sv */
// checker for the supply supervisor: port relations of reset, gating and watchdog
// assumes bound to the design top, one clock, reset active low
`timescale 1ns/1ps
module supervisor_chk #(
  parameter int TICK_DIV    = 2,
  parameter int WDOG_TICKS  = 20,
  parameter int PULSE_TICKS = 5
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic SUPPLY_OK,
  input wire logic PF_ABOVE,
  input wire logic MAIN_ABOVE_HI,
  input wire logic MAIN_ABOVE_LO,
  input wire logic WATCHDOG_TOGGLE_IN,
  input wire logic CHIP_SELECT_IN_N,
  input wire logic RESET_N,
  input wire logic RESET,
  input wire logic POWER_FAIL_WARN_N,
  input wire logic CHIP_SELECT_OUT_N,
  input wire logic SUPPLY_LOW_N,
  input wire logic WATCHDOG_TIMEOUT_OUT_N,
  input wire logic MAIN_SUPPLY_ACTIVE_N,
  input wire logic BACKUP_SELECT
);
  localparam int PW = PULSE_TICKS * TICK_DIV; // pulse in clocks
  localparam int WT = WDOG_TICKS * TICK_DIV;  // timeout in clocks
  int   lo_q, lo_d;   // clocks reset low with supply good
  int   hi_q, hi_d;   // clocks since toggle with reset high
  logic wdi_q, wdi_d; // previous toggle level
  // next counts
  always_comb begin
    lo_d = (RESET_N || !SUPPLY_OK) ? 0 : lo_q + 1;
    hi_d = (!RESET_N || WATCHDOG_TOGGLE_IN != wdi_q) ? 0 : hi_q + 1;
    wdi_d = WATCHDOG_TOGGLE_IN;
  end
  // register counts
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      lo_q <= 0;
      hi_q <= 0;
      wdi_q <= 1'b0;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
      wdi_q <= wdi_d;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_rst_complement: assert property (RESET == !RESET_N)
    else $error("reset outputs not complementary");
  a_low_holds_reset: assert property (!SUPPLY_OK [*3] |=> !RESET_N && !SUPPLY_LOW_N)
    else $error("low supply without reset");
  a_cs_forced_high: assert property (!SUPPLY_OK [*3] |=> CHIP_SELECT_OUT_N && WATCHDOG_TIMEOUT_OUT_N)
    else $error("gate or flag wrong on low supply");
  a_cs_pass: assert property ((SUPPLY_OK && $stable(CHIP_SELECT_IN_N)) [*3] |=>
      CHIP_SELECT_OUT_N == $past(CHIP_SELECT_IN_N))
    else $error("chip-select not passed");
  a_pfail_warn: assert property (!PF_ABOVE [*3] |=> !POWER_FAIL_WARN_N)
    else $error("warning missing");
  a_backup_mode: assert property ((!MAIN_ABOVE_LO && !MAIN_ABOVE_HI) [*3] |=>
      BACKUP_SELECT && MAIN_SUPPLY_ACTIVE_N && !POWER_FAIL_WARN_N)
    else $error("backup mode wrong");
  a_main_active: assert property (MAIN_ABOVE_HI [*3] |=> !MAIN_SUPPLY_ACTIVE_N && !BACKUP_SELECT)
    else $error("main mode wrong");
  a_wdo_with_reset: assert property ($fell(WATCHDOG_TIMEOUT_OUT_N) |-> $fell(RESET_N))
    else $error("flag without reset pulse");
  a_pulse_width: assert property ($rose(RESET_N) |-> lo_q >= PW - 1 && lo_q <= PW + TICK_DIV + 4)
    else $error("reset pulse width wrong");
  // the tick phase at the restart may shorten the timeout by up to one tick
  a_wdog_early: assert property ($fell(RESET_N) && $past(SUPPLY_OK, 3) |-> hi_q >= WT - TICK_DIV)
    else $error("watchdog expired early");
endmodule
bind supply_supervisor_watchdog supervisor_chk #(.TICK_DIV(TICK_DIV), .WDOG_TICKS(WDOG_TICKS),
  .PULSE_TICKS(PULSE_TICKS)) chk (.*);

/* tb/cpu_model.sv */
// processor model: services the watchdog line while its software runs
// assumes one clock shared with the supervisor
`timescale 1ns/1ps
module cpu_model (
  input  wire logic clk,
  input  wire logic run,      // software alive
  output logic      toggle_q  // watchdog line
);
  logic [2:0] cnt_q = 3'h0; // toggle spacing
  initial toggle_q = 1'b0;
  // one transition every 8 clocks, well inside the timeout
  always_ff @(posedge clk) begin
    cnt_q <= cnt_q + 3'h1;
    if (run && cnt_q == 3'h7) begin
      toggle_q <= ~toggle_q;
    end
  end
endmodule

/* tb/test_supply_supervisor_watchdog.sv */
// self-checking bench for the supply supervisor and watchdog
// assumes design, checker and processor model compiled before it
`timescale 1ns/1ps
module test_supply_supervisor_watchdog;
  logic CLK_SYS = 1'b0, RST_N = 1'b0, SUPPLY_OK = 1'b1, PF_ABOVE = 1'b1;
  logic MAIN_ABOVE_HI = 1'b1, MAIN_ABOVE_LO = 1'b1, WDI_FLOATING = 1'b0;
  logic CHIP_SELECT_IN_N = 1'b1, run = 1'b1, WATCHDOG_TOGGLE_IN, RESET_N, RESET;
  logic POWER_FAIL_WARN_N, CHIP_SELECT_OUT_N, SUPPLY_LOW_N, WATCHDOG_TIMEOUT_OUT_N;
  logic MAIN_SUPPLY_ACTIVE_N, BACKUP_SELECT;
  int error_cnt = 0, check_count = 0, n;
  // 100 MHz clock
  always #5 CLK_SYS = ~CLK_SYS;
  supply_supervisor_watchdog #(.TICK_DIV(2), .WDOG_TICKS(20), .PULSE_TICKS(5)) dut (.*);
  cpu_model cpu (.clk(CLK_SYS), .run(run), .toggle_q(WATCHDOG_TOGGLE_IN));
  // wait k edges, then let outputs settle
  task automatic step(input int k);
    repeat (k) @(posedge CLK_SYS);
    #1;
  endtask
  // compare seen against expected
  task automatic chk(input logic v, input logic e);
    check_count++;
    if (v !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %b expected %b", $time, v, e);
    end
  endtask
  // count clocks until reset drops, bounded
  task automatic until_rst(output int k);
    k = 0;
    while (RESET_N === 1'b1 && k < 200) begin
      step(1);
      k++;
    end
  endtask
  // verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #20000;
    error_cnt++;
    test_done;
  end
  initial begin
    step(5);
    @(posedge CLK_SYS) RST_N <= 1'b1;
    step(6);
    chk(RESET_N, 1'b0);
    step(14);
    chk(RESET, 1'b0);
    @(posedge CLK_SYS) CHIP_SELECT_IN_N <= 1'b0;
    step(4);
    chk(CHIP_SELECT_OUT_N, 1'b0);
    @(posedge CLK_SYS) PF_ABOVE <= 1'b0;
    step(4);
    chk(POWER_FAIL_WARN_N, 1'b0);
    @(posedge CLK_SYS) PF_ABOVE <= 1'b1;
    SUPPLY_OK <= 1'b0;
    step(4);
    chk(RESET, 1'b1);
    chk(SUPPLY_LOW_N, 1'b0);
    chk(CHIP_SELECT_OUT_N, 1'b1);
    @(posedge CLK_SYS) SUPPLY_OK <= 1'b1;
    step(4);
    chk(SUPPLY_LOW_N, 1'b1);
    chk(RESET_N, 1'b0);
    step(160);
    chk(RESET_N, 1'b1);
    // software stops: expiry, then repeats
    @(posedge CLK_SYS) run <= 1'b0;
    until_rst(n);
    chk(n >= 30 && n <= 55, 1'b1);
    chk(WATCHDOG_TIMEOUT_OUT_N, 1'b0);
    step(16);
    chk(WATCHDOG_TIMEOUT_OUT_N, 1'b0);
    chk(RESET_N, 1'b1);
    until_rst(n);
    chk(n >= 30 && n <= 44, 1'b1);
    step(16);
    @(posedge CLK_SYS) run <= 1'b1;
    step(14);
    chk(WATCHDOG_TIMEOUT_OUT_N, 1'b1);
    @(posedge CLK_SYS) run <= 1'b0;
    until_rst(n);
    @(posedge CLK_SYS) SUPPLY_OK <= 1'b0;
    step(4);
    chk(WATCHDOG_TIMEOUT_OUT_N, 1'b1);
    @(posedge CLK_SYS) WDI_FLOATING <= 1'b1;
    SUPPLY_OK <= 1'b1;
    step(200);
    chk(RESET_N & WATCHDOG_TIMEOUT_OUT_N, 1'b1);
    // switchover with hysteresis
    @(posedge CLK_SYS) MAIN_ABOVE_HI <= 1'b0;
    step(4);
    chk(BACKUP_SELECT, 1'b0);
    @(posedge CLK_SYS) MAIN_ABOVE_LO <= 1'b0;
    step(4);
    chk(MAIN_SUPPLY_ACTIVE_N, 1'b1);
    chk(POWER_FAIL_WARN_N, 1'b0);
    @(posedge CLK_SYS) MAIN_ABOVE_LO <= 1'b1;
    step(4);
    chk(BACKUP_SELECT, 1'b1);
    @(posedge CLK_SYS) MAIN_ABOVE_HI <= 1'b1;
    step(4);
    chk(MAIN_SUPPLY_ACTIVE_N, 1'b0);
    test_done;
  end
endmodule
